// ==== design/dcmr_pkg.sv ====
// constants, types and rule overview for the debug component management registers
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - word transfers only, address bits 1:0 ignored
// - word address widens per doubled block count
// - 0xF00-0xFFC holds management registers only
// - integration control at 0xF00, gap reads zero
// - claim set and clear at 0xFA0, 0xFA4
// - lock access write-only, lock state read-only
// - component registers upward, integration ones downward
// - reserved and unimplemented read zero, ignore writes
// - wrong-direction access treated as reserved
// - reserved-zero reads zeros, writes ignored
// - reserved values mapped onto permitted behaviour
// - fixed preamble bytes in identification words
// - class code in bits 7:4 of second word
// - identification words read-only, upper bits zero
// - eight peripheral words at 0xFD0-0xFEC, split order
// - minor revision from zero-reset registers
// - design change must change a revision field
// - valid bits low, little-endian full words
// - part number split across first two words
// - designer-code standard flag bit reads one
// - unimplemented management locations read zero, ignore writes
package dcmr_pkg;
	//------------------------------------------------------------
	// register word offsets within the 4KB block
	//------------------------------------------------------------
	localparam logic [11:0] OFS_INTEG_CTRL = 12'h0F00;
	localparam logic [11:0] OFS_MGMT_BASE = 12'h0F00;
	localparam logic [11:0] OFS_CLAIM_SET = 12'h0FA0;
	localparam logic [11:0] OFS_CLAIM_CLR = 12'h0FA4;
	localparam logic [11:0] OFS_DEV_AFF_0 = 12'h0FA8;
	localparam logic [11:0] OFS_DEV_AFF_1 = 12'h0FAC;
	localparam logic [11:0] OFS_LOCK_ACCESS = 12'h0FB0;
	localparam logic [11:0] OFS_LOCK_STATE = 12'h0FB4;
	localparam logic [11:0] OFS_AUTH_STATE = 12'h0FB8;
	localparam logic [11:0] OFS_DEV_ARCH = 12'h0FBC;
	localparam logic [11:0] OFS_DEV_CFG_2 = 12'h0FC0;
	localparam logic [11:0] OFS_DEV_CFG_1 = 12'h0FC4;
	localparam logic [11:0] OFS_DEV_CFG_0 = 12'h0FC8;
	localparam logic [11:0] OFS_DEV_TYPE = 12'h0FCC;
	localparam logic [11:0] OFS_PID_4 = 12'h0FD0;
	localparam logic [11:0] OFS_PID_5 = 12'h0FD4;
	localparam logic [11:0] OFS_PID_6 = 12'h0FD8;
	localparam logic [11:0] OFS_PID_7 = 12'h0FDC;
	localparam logic [11:0] OFS_PID_0 = 12'h0FE0;
	localparam logic [11:0] OFS_PID_1 = 12'h0FE4;
	localparam logic [11:0] OFS_PID_2 = 12'h0FE8;
	localparam logic [11:0] OFS_PID_3 = 12'h0FEC;
	localparam logic [11:0] OFS_CID_0 = 12'h0FF0;
	localparam logic [11:0] OFS_CID_1 = 12'h0FF4;
	localparam logic [11:0] OFS_CID_2 = 12'h0FF8;
	localparam logic [11:0] OFS_CID_3 = 12'h0FFC;
	//------------------------------------------------------------
	// fixed field values and positions
	//------------------------------------------------------------
	localparam logic [7:0] PREAMBLE_BYTE_0 = 8'h0D;
	localparam logic [3:0] PREAMBLE_NIBBLE_1 = 4'h0;
	localparam logic [7:0] PREAMBLE_BYTE_2 = 8'h05;
	localparam logic [7:0] PREAMBLE_BYTE_3 = 8'hB1;
	localparam logic [3:0] CLASS_MGMT = 4'h9;
	localparam logic [3:0] CLASS_ROM_TABLE = 4'h1;
	localparam logic [3:0] CLASS_LEGACY = 4'hF;
	localparam logic STD_DESIGNER_FLAG = 1'b1;
	localparam int LOCK_STATE_IMPL_BIT = 0;
	localparam int LOCK_STATE_LOCKED_BIT = 1;
	localparam int BLOCK_ADDR_BITS = 12;
	//------------------------------------------------------------
	// values after reset
	//------------------------------------------------------------
	localparam logic RST_INTEG_MODE = 1'b0;
	localparam logic RST_LOCKED = 1'b1;
	localparam logic [3:0] RST_MINOR_FIX = 4'h0;
	//------------------------------------------------------------
	// block state, one packed record
	//------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic integ_mode;
		logic [7:0] claim_tags;
		logic locked;
		logic [3:0] minor_fix;
	} dcmr_state_type;
endpackage

// ==== design/dcmr_regs.sv ====
// management register block of a debug-visible component
`timescale 1ns/1ps
module dcmr_regs #(
	parameter int BLOCKS_LOG2 = 0,
	parameter int CLAIM_BITS = 4,
	parameter logic [11:0] PART_NUMBER = 12'h0001, // arbitrary value
	parameter logic [6:0] DESIGNER_ID = 7'h01, // arbitrary value
	parameter logic [3:0] DESIGNER_CONT = 4'h0, // arbitrary value
	parameter logic [3:0] REVISION = 4'h0, // arbitrary value
	parameter logic [3:0] CUSTOMER_MODIFIED = 4'h0,
	parameter logic [3:0] COMPONENT_CLASS = dcmr_pkg::CLASS_MGMT,
	parameter logic [31:0] LOCK_KEY = 32'h0000_0001, // arbitrary value
	parameter logic [31:0] AUTH_STATE_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_ARCH_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_TYPE_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_CFG_0_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_CFG_1_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_CFG_2_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_AFF_0_VAL = 32'h0000_0000,
	parameter logic [31:0] DEV_AFF_1_VAL = 32'h0000_0000
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic DEBUG_BUS_SEL,
	input wire logic DEBUG_BUS_ENABLE,
	input wire logic DEBUG_BUS_WRITE,
	input wire logic [dcmr_pkg::BLOCK_ADDR_BITS+BLOCKS_LOG2-1:2] DEBUG_BUS_ADDRESS,
	input wire logic [31:0] DEBUG_BUS_WDATA,
	output logic [31:0] DEBUG_BUS_RDATA,
	output logic DEBUG_BUS_READY,
	output logic INTEGRATION_MODE
);
	import dcmr_pkg::*;

	//------------------------------------------------------------
	// decode helpers
	//------------------------------------------------------------
	localparam int AW = BLOCK_ADDR_BITS + BLOCKS_LOG2;
	localparam logic [7:0] CLAIM_MASK = 8'((9'h001 << CLAIM_BITS) - 9'h001);

	// word offset within the 4KB block; byte lanes 1:0 are not decoded
	function automatic logic [11:0] block_offset(input logic [AW-1:2] a);
		block_offset = {a[11:2], 2'b00};
	endfunction

	// management registers live only in the lowest 4KB block
	function automatic logic in_mgmt_block(input logic [AW-1:2] a);
		logic [AW-1:2] upper;
		upper = a;
		upper[11:2] = 10'h000;
		in_mgmt_block = (upper == '0);
	endfunction

	dcmr_state_type st_reg;
	dcmr_state_type st_next;
	logic setup_phase;
	logic wr_access;
	logic [11:0] ofs;
	logic mgmt_hit;
	logic [31:0] rd_word;

	assign setup_phase = DEBUG_BUS_SEL & ~DEBUG_BUS_ENABLE;
	assign wr_access = DEBUG_BUS_SEL & DEBUG_BUS_ENABLE & DEBUG_BUS_WRITE & st_reg.ready;
	assign ofs = block_offset(DEBUG_BUS_ADDRESS);
	// component-specific space below the management area is unused here
	assign mgmt_hit = in_mgmt_block(DEBUG_BUS_ADDRESS) && (ofs >= OFS_MGMT_BASE);

	//------------------------------------------------------------
	// read multiplexer
	//------------------------------------------------------------
	// pure decode: reading never touches state
	always_comb begin
		rd_word = 32'h0000_0000;
		if (mgmt_hit) begin
			case (ofs)
				OFS_INTEG_CTRL: rd_word = {31'h0, st_reg.integ_mode};
				OFS_CLAIM_SET: rd_word = {24'h0, CLAIM_MASK};
				OFS_CLAIM_CLR: rd_word = {24'h0, st_reg.claim_tags};
				OFS_DEV_AFF_0: rd_word = DEV_AFF_0_VAL;
				OFS_DEV_AFF_1: rd_word = DEV_AFF_1_VAL;
				OFS_LOCK_ACCESS: rd_word = 32'h0000_0000;
				OFS_LOCK_STATE: begin
					rd_word = 32'h0000_0000;
					rd_word[LOCK_STATE_IMPL_BIT] = 1'b1;
					rd_word[LOCK_STATE_LOCKED_BIT] = st_reg.locked;
				end
				OFS_AUTH_STATE: rd_word = AUTH_STATE_VAL;
				OFS_DEV_ARCH: rd_word = DEV_ARCH_VAL;
				OFS_DEV_CFG_2: rd_word = DEV_CFG_2_VAL;
				OFS_DEV_CFG_1: rd_word = DEV_CFG_1_VAL;
				OFS_DEV_CFG_0: rd_word = DEV_CFG_0_VAL;
				OFS_DEV_TYPE: rd_word = DEV_TYPE_VAL;
				OFS_PID_4: rd_word = {24'h0, 4'h0, DESIGNER_CONT};
				OFS_PID_5: rd_word = 32'h0000_0000;
				OFS_PID_6: rd_word = 32'h0000_0000;
				OFS_PID_7: rd_word = 32'h0000_0000;
				OFS_PID_0: rd_word = {24'h0, PART_NUMBER[7:0]};
				OFS_PID_1: rd_word = {24'h0, DESIGNER_ID[3:0], PART_NUMBER[11:8]};
				// revision plus minor fix distinguish any changed design
				OFS_PID_2: rd_word = {24'h0, REVISION, STD_DESIGNER_FLAG, DESIGNER_ID[6:4]};
				OFS_PID_3: rd_word = {24'h0, st_reg.minor_fix, CUSTOMER_MODIFIED};
				OFS_CID_0: rd_word = {24'h0, PREAMBLE_BYTE_0};
				OFS_CID_1: rd_word = {24'h0, COMPONENT_CLASS, PREAMBLE_NIBBLE_1};
				OFS_CID_2: rd_word = {24'h0, PREAMBLE_BYTE_2};
				OFS_CID_3: rd_word = {24'h0, PREAMBLE_BYTE_3};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	//------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------
	// writes land in the access phase; all else is ignored
	always_comb begin
		st_next = st_reg;
		// answer ready in the access phase right after setup: no wait states
		st_next.ready = setup_phase;
		st_next.rdata = (setup_phase && !DEBUG_BUS_WRITE) ? rd_word : 32'h0000_0000;
		// minor fix field only ever holds its reset value
		st_next.minor_fix = st_reg.minor_fix;
		if (wr_access && mgmt_hit) begin
			case (ofs)
				OFS_LOCK_ACCESS: begin
					// any value other than the key relocks; always accepted
					st_next.locked = (DEBUG_BUS_WDATA != LOCK_KEY);
				end
				OFS_INTEG_CTRL: begin
					if (!st_reg.locked) begin
						st_next.integ_mode = DEBUG_BUS_WDATA[0];
					end
				end
				OFS_CLAIM_SET: begin
					// bits beyond the implemented tags are dropped, not stored
					if (!st_reg.locked) begin
						st_next.claim_tags = st_reg.claim_tags |
							(DEBUG_BUS_WDATA[7:0] & CLAIM_MASK);
					end
				end
				OFS_CLAIM_CLR: begin
					if (!st_reg.locked) begin
						st_next.claim_tags = st_reg.claim_tags &
							~(DEBUG_BUS_WDATA[7:0] & CLAIM_MASK);
					end
				end
				default: st_next.locked = st_reg.locked;
			endcase
		end
	end

	//------------------------------------------------------------
	// state register
	//------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_reg.rdata <= 32'h0000_0000;
			st_reg.ready <= 1'b0;
			st_reg.integ_mode <= RST_INTEG_MODE;
			st_reg.claim_tags <= 8'h00;
			st_reg.locked <= RST_LOCKED;
			st_reg.minor_fix <= RST_MINOR_FIX;
		end else begin
			st_reg <= st_next;
		end
	end

	assign DEBUG_BUS_RDATA = st_reg.rdata;
	assign DEBUG_BUS_READY = st_reg.ready;
	assign INTEGRATION_MODE = st_reg.integ_mode;
endmodule

// ==== test/dcmr_master.sv ====
// bus master model issuing single word transfers to the register block
`timescale 1ns/1ps
module dcmr_master (
	input wire logic clk,
	input wire logic ready,
	input wire logic [31:0] rdata,
	output logic sel,
	output logic en,
	output logic wr,
	output logic [9:0] addr,
	output logic [31:0] wdata
);
	// idle bus at time zero
	initial begin
		sel = 1'b0;
		en = 1'b0;
		wr = 1'b0;
		addr = 10'h0;
		wdata = 32'h0;
	end
	// setup, then access held until ready is sampled or four clocks pass; whole words only
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		@(negedge clk);
		sel = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		@(negedge clk);
		en = 1'b1;
		ok = 1'b0;
		repeat (4) begin
			@(posedge clk);
			if (ready === 1'b1) begin
				q = rdata;
				ok = 1'b1;
				break;
			end
		end
		// released address and data lines must not keep the last value
		@(negedge clk);
		sel = 1'b0;
		en = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
	endtask
endmodule

// ==== test/dcmr_regs_assertions.sv ====
// timing and read-value checks at the register block ports
`timescale 1ns/1ps
module dcmr_regs_assertions #(parameter int BLOCKS_LOG2 = 0) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic DEBUG_BUS_SEL,
	input wire logic DEBUG_BUS_ENABLE,
	input wire logic DEBUG_BUS_WRITE,
	input wire logic [dcmr_pkg::BLOCK_ADDR_BITS+BLOCKS_LOG2-1:2] DEBUG_BUS_ADDRESS,
	input wire logic [31:0] DEBUG_BUS_WDATA,
	input wire logic [31:0] DEBUG_BUS_RDATA,
	input wire logic DEBUG_BUS_READY,
	input wire logic INTEGRATION_MODE
);
	import dcmr_pkg::*;
	// short names for setup phase, read answer, word address and data
	wire st = DEBUG_BUS_SEL && !DEBUG_BUS_ENABLE;
	wire rd = DEBUG_BUS_READY && !DEBUG_BUS_WRITE;
	wire [9:0] a = DEBUG_BUS_ADDRESS[11:2];
	wire [31:0] q = DEBUG_BUS_RDATA;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	//------------------------------------------------------------
	// answer timing and read values
	//------------------------------------------------------------
	a_ready_after_setup: assert property (st |=> DEBUG_BUS_READY)
		else $error("no ready after setup");
	a_ready_only_answer: assert property (!st |=> !DEBUG_BUS_READY)
		else $error("ready without setup");
	a_rdata_idle_zero: assert property (!rd |-> q == 32'h0)
		else $error("read data outside read answer");
	a_preamble_first: assert property (rd && a == 10'h3FC |-> q == 32'hD)
		else $error("first preamble word wrong");
	a_class_field: assert property (rd && a == 10'h3FD |-> q == 32'h90)
		else $error("class word wrong");
	a_lower_words_zero: assert property (rd && a < 10'h3C0 |-> q == 32'h0)
		else $error("component area not zero");
	a_gap_zero: assert property (rd && a inside {[10'h3C1:10'h3E7]} |-> q == 32'h0)
		else $error("reserved gap not zero");
	a_lock_access_raz: assert property (rd && a == 10'h3EC |-> q == 32'h0)
		else $error("write-only word read nonzero");
	// the mode pin moves only on a write to its own word
	a_integ_hold: assert property (!(DEBUG_BUS_READY && DEBUG_BUS_WRITE && a == 10'h3C0)
		|=> $stable(INTEGRATION_MODE)) else $error("mode changed without write");
	c_id_read: cover property (rd && a == 10'h3FF);
	c_lock_write: cover property (DEBUG_BUS_READY && DEBUG_BUS_WRITE && a == 10'h3EC);
	c_mode_set: cover property ($rose(INTEGRATION_MODE));
endmodule
bind dcmr_regs dcmr_regs_assertions #(.BLOCKS_LOG2(BLOCKS_LOG2)) u_dcmr_regs_assertions (.CLK,
	.RST, .DEBUG_BUS_SEL, .DEBUG_BUS_ENABLE, .DEBUG_BUS_WRITE, .DEBUG_BUS_ADDRESS,
	.DEBUG_BUS_WDATA, .DEBUG_BUS_RDATA, .DEBUG_BUS_READY, .INTEGRATION_MODE);

// ==== test/dcmr_regs_tb.sv ====
// self-checking bench for the management register block
`timescale 1ns/1ps
module dcmr_regs_tb;
	import dcmr_pkg::*;
	typedef struct packed {
		logic w;
		logic [9:0] a;
		logic [31:0] d;
	} dcmr_row_type;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic sel, en, wr, ready, imode, ok;
	logic [9:0] addr;
	logic [31:0] wdata, rdata, q;
	int num_errors = 0;
	int comparisons = 0;
	// reads carry the expected word, writes the data; locked until row 16, relocked at row 29
	dcmr_row_type rows [35] = '{'{1'b0, 10'h3FC, 32'hD}, '{1'b0, 10'h3FD, 32'h90},
		'{1'b0, 10'h3FE, 32'h5}, '{1'b0, 10'h3FF, 32'hB1}, '{1'b0, 10'h3F8, 32'h1},
		'{1'b0, 10'h3F9, 32'h10}, '{1'b0, 10'h3FA, 32'h8}, '{1'b0, 10'h3FB, 32'h0},
		'{1'b0, 10'h3F4, 32'h0}, '{1'b0, 10'h3F7, 32'h0}, '{1'b0, 10'h3ED, 32'h3},
		'{1'b1, 10'h3FC, 32'hFFFF_FFFF}, '{1'b0, 10'h3FC, 32'hD}, '{1'b0, 10'h3EC, 32'h0},
		'{1'b1, 10'h3C0, 32'h1}, '{1'b0, 10'h3C0, 32'h0}, '{1'b1, 10'h3EC, 32'h1},
		'{1'b0, 10'h3ED, 32'h1}, '{1'b1, 10'h3C0, 32'h1}, '{1'b0, 10'h3C0, 32'h1},
		'{1'b1, 10'h3C1, 32'hFFFF_FFFF}, '{1'b0, 10'h3C1, 32'h0}, '{1'b0, 10'h3E7, 32'h0},
		'{1'b0, 10'h000, 32'h0}, '{1'b1, 10'h3E8, 32'hF}, '{1'b0, 10'h3E9, 32'hF},
		'{1'b0, 10'h3E8, 32'hF}, '{1'b1, 10'h3E9, 32'h5}, '{1'b0, 10'h3E9, 32'hA},
		'{1'b1, 10'h3EC, 32'h0}, '{1'b0, 10'h3ED, 32'h3}, '{1'b1, 10'h3E9, 32'hF},
		'{1'b0, 10'h3E9, 32'hA}, '{1'b0, 10'h3EA, 32'h0}, '{1'b0, 10'h3EE, 32'h0}};
	dcmr_master u_dcmr_master (.clk(CLK), .ready, .rdata, .sel, .en, .wr, .addr, .wdata);
	dcmr_regs u_dcmr_regs (.CLK, .RST, .DEBUG_BUS_SEL(sel), .DEBUG_BUS_ENABLE(en),
		.DEBUG_BUS_WRITE(wr), .DEBUG_BUS_ADDRESS(addr), .DEBUG_BUS_WDATA(wdata),
		.DEBUG_BUS_RDATA(rdata), .DEBUG_BUS_READY(ready), .INTEGRATION_MODE(imode));
	//------------------------------------------------------------
	// clock, compare tasks, closing
	//------------------------------------------------------------
	initial forever #5 CLK = ~CLK;
	task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic s);
		chk32(n, {31'h0, e}, {31'h0, s});
	endtask
	// one transfer; a missing ready counts against the answer timing
	task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
		u_dcmr_master.xfer(w, a, d, q, ok);
		chk1("ready", 1'b1, ok);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// a hang ends the run as a failure
	initial begin
		repeat (1000) @(posedge CLK);
		num_errors++;
		end_of_test();
	end
	// table pass, then a reset in mid-run must restore lock, claims and mode
	initial begin
		repeat (10) @(negedge CLK);
		RST = 1'b0;
		foreach (rows[i]) begin
			acc(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk32("rdata", rows[i].d, q);
		end
		chk1("mode", 1'b1, imode);
		@(negedge CLK);
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		chk1("mode", 1'b0, imode);
		chk1("ready", 1'b0, ready);
		chk32("rdata", 32'h0, rdata);
		acc(1'b0, 10'h3ED, 32'h0);
		chk32("lock", 32'h3, q);
		acc(1'b0, 10'h3E9, 32'h0);
		chk32("claim", 32'h0, q);
		end_of_test();
	end
endmodule
